// file: rtl/acmp_cfg.svh
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH
// =====================================================
// Register byte addresses
`define ACMP_CTRL_OFFS      12'h000
`define ACMP_DIGITAL_INPUT_DISABLE_OFFS      12'h004
`define ACMP_IRQ_STAT_OFFS  12'h008
`define ACMP_IRQ_CLR_OFFS   12'h00C
`define ACMP_IRQ_EN_OFFS    12'h010
`define ACMP_PINS_OFFS      12'h014
// =====================================================
// Control register field positions
`define ACMP_POWER_OFF_BIT  7
`define ACMP_REF_SEL_BIT    6
`define ACMP_OUT_BIT        5
`define ACMP_FLAG_BIT       4
`define ACMP_IRQ_EN_BIT     3
`define ACMP_CAPT_BIT       2
`define ACMP_MODE_HI_BIT    1
`define ACMP_MODE_LO_BIT    0
// =====================================================
// Digital input disable field positions
`define ACMP_NEG_OFF_BIT    1
`define ACMP_POS_OFF_BIT    0
// =====================================================
// Reset values
`define ACMP_CTRL_RST       8'h00
`define ACMP_DIGITAL_INPUT_DISABLE_RST       8'h00
`define ACMP_IRQ_EN_RST     8'h00
// =====================================================
// Status event bit positions
`define ACMP_EV_CMP_BIT     0
`define ACMP_EV_RISE_BIT    1
`define ACMP_EV_FALL_BIT    2
`endif

// file: rtl/acmp_pkg.sv
// =====================================================
// Types shared by the comparator control block
package acmp_pkg;
  // Event mode codes
  typedef enum logic [1:0] {
    ACMP_MODE_TOGGLE = 2'b00,
    ACMP_MODE_RSVD   = 2'b01,
    ACMP_MODE_FALL   = 2'b10,
    ACMP_MODE_RISE   = 2'b11
  } acmp_mode_t;
  // APB access phase tracker
  typedef enum logic [0:0] {
    ACMP_BUS_IDLE = 1'b0,
    ACMP_BUS_ACC  = 1'b1
  } acmp_bus_st_t;
endpackage

// file: rtl/acmp_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Link between top and the synchroniser / edge detector
interface acmp_sync_if;
  logic raw;        // Asynchronous comparator output
  logic sync;       // Synchronised level
  logic rise;       // One-cycle rising pulse
  logic fall;       // One-cycle falling pulse
  modport top  (output raw, input sync, input rise, input fall);
  modport det  (input raw, output sync, output rise, output fall);
endinterface
`default_nettype wire

// file: rtl/acmp_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Two-stage synchroniser plus edge detector
module acmp_sync_edge
  import acmp_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  acmp_sync_if.det   sif
);
  // All state in one struct
  typedef struct packed {
    logic meta;   // First stage, read only by the second
    logic sync;   // Second stage
    logic prev;   // Sync delayed one cycle
  } acmp_se_st_t;
  acmp_se_st_t st_q;
  acmp_se_st_t st_d;

  // =====================================================
  // Next state
  always_comb
  begin
    st_d      = st_q;
    st_d.meta = sif.raw;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  // =====================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Edges from synchronised level only
  assign sif.sync = st_q.sync;
  assign sif.rise = st_q.sync & ~st_q.prev;
  assign sif.fall = ~st_q.sync & st_q.prev;

  // =====================================================
  // Checks
  sync_delay_a : assert property (@(posedge pclk) disable iff (!presetn)
    st_q.sync == $past(sif.raw, 2)) else $error("sync level not two-stage");
  edge_pair_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(sif.rise && sif.fall)) else $error("rise and fall together");
endmodule
`default_nettype wire

// file: rtl/acmp_top.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_cfg.svh"
module acmp_top
  import acmp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        comparator_raw,
  output logic             comparator_power_off,
  output logic             reference_select,
  input  wire logic        global_irq_enable,
  input  wire logic        vector_ack,
  output logic             comparator_irq,
  input  wire logic        capture_pin_in,
  output logic             capture_in,
  input  wire logic        positive_input_pin,
  input  wire logic        negative_input_pin,
  output logic             pos_pin_buffer_off,
  output logic             neg_pin_buffer_off,
  output logic             pos_pin_port_in,
  output logic             neg_pin_port_in,
  output logic             status_irq
);
  // =====================================================
  // State
  typedef struct packed {
    logic             power_off;    // Comparator power switch
    logic             ref_sel;      // Bandgap replaces positive pin
    logic             flag;         // Comparator event flag
    logic             irq_en;       // Comparator interrupt enable
    logic             capt;         // Capture routing enable
    acmp_mode_t       mode;         // Event mode
    logic       [1:0] digital_input_disable;         // Pin buffer disables
    logic       [2:0] stat;         // Sticky event status
    logic       [2:0] sen;          // Status interrupt enable
    logic       [1:0] pin_m;        // Pin sync first stage
    logic       [1:0] pin_s;        // Pin sync second stage
    logic      [31:0] rdata;        // Registered read data
  } acmp_st_t;
  acmp_st_t st_q;
  acmp_st_t st_d;

  acmp_sync_if sif ();
  logic wr_acc;                      // Write completes this cycle
  logic rd_acc;                      // Read in setup or access cycle
  logic ev_hit;                      // Event matching mode
  logic [31:0] rd_mux;               // Read data source

  // =====================================================
  // Synchroniser / edge detector
  assign sif.raw = comparator_raw;
  acmp_sync_edge u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  // Zero-wait APB: setup cycle then one access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~pwrite;    // Sampled in setup, shown in access

  // Mode decode, used for flag setting
  function automatic logic mode_match(input acmp_mode_t m, input logic r, input logic f);
    case (m)
      ACMP_MODE_TOGGLE: mode_match = r | f;
      ACMP_MODE_FALL:   mode_match = f;
      ACMP_MODE_RISE:   mode_match = r;
      default:          mode_match = 1'b0;
    endcase
  endfunction

  assign ev_hit = mode_match(st_q.mode, sif.rise, sif.fall);

  // =====================================================
  // Read decode
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (paddr == `ACMP_CTRL_OFFS)
    begin
      rd_mux[`ACMP_POWER_OFF_BIT] = st_q.power_off;
      rd_mux[`ACMP_REF_SEL_BIT]   = st_q.ref_sel;
      rd_mux[`ACMP_OUT_BIT]       = sif.sync;
      rd_mux[`ACMP_FLAG_BIT]      = st_q.flag;
      rd_mux[`ACMP_IRQ_EN_BIT]    = st_q.irq_en;
      rd_mux[`ACMP_CAPT_BIT]      = st_q.capt;
      rd_mux[`ACMP_MODE_HI_BIT:`ACMP_MODE_LO_BIT] = st_q.mode;
    end
    else if (paddr == `ACMP_DIGITAL_INPUT_DISABLE_OFFS)
      rd_mux[1:0] = st_q.digital_input_disable;
    else if (paddr == `ACMP_IRQ_STAT_OFFS)
      rd_mux[2:0] = st_q.stat;
    else if (paddr == `ACMP_IRQ_EN_OFFS)
      rd_mux[2:0] = st_q.sen;
    else if (paddr == `ACMP_PINS_OFFS)
    begin
      // Port view of the pins, zero while buffer off
      rd_mux[`ACMP_NEG_OFF_BIT] = st_q.pin_s[1] & ~st_q.digital_input_disable[1];
      rd_mux[`ACMP_POS_OFF_BIT] = st_q.pin_s[0] & ~st_q.digital_input_disable[0];
    end
    else
      rd_mux = 32'h0000_0000;   // Unmapped reads zero
  end

  // =====================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    // Pin synchronisers
    st_d.pin_m = {negative_input_pin, positive_input_pin};
    st_d.pin_s = st_q.pin_m;
    if (rd_acc)
      st_d.rdata = rd_mux;
    // Register writes
    if (wr_acc)
    begin
      if (paddr == `ACMP_CTRL_OFFS)
      begin
        st_d.power_off = pwdata[`ACMP_POWER_OFF_BIT];
        st_d.ref_sel   = pwdata[`ACMP_REF_SEL_BIT];
        st_d.irq_en    = pwdata[`ACMP_IRQ_EN_BIT];
        st_d.capt      = pwdata[`ACMP_CAPT_BIT];
        st_d.mode      = acmp_mode_t'(pwdata[`ACMP_MODE_HI_BIT:`ACMP_MODE_LO_BIT]);
        if (pwdata[`ACMP_FLAG_BIT])
          st_d.flag = 1'b0;
      end
      else if (paddr == `ACMP_DIGITAL_INPUT_DISABLE_OFFS)
        st_d.digital_input_disable = pwdata[1:0];
      else if (paddr == `ACMP_IRQ_CLR_OFFS)
        st_d.stat = st_q.stat & ~pwdata[2:0];
      else if (paddr == `ACMP_IRQ_EN_OFFS)
        st_d.sen = pwdata[2:0];
      else
        st_d.sen = st_q.sen;    // Unmapped write ignored
    end
    // Vector acknowledge clears the flag
    if (vector_ack)
      st_d.flag = 1'b0;
    // Set wins over any clear in the same cycle
    if (ev_hit)
      st_d.flag = 1'b1;
    st_d.stat = st_d.stat | {sif.fall, sif.rise, ev_hit};
  end

  // =====================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= '0;   // Every field resets to zero
    else
      st_q <= st_d;
  end

  // =====================================================
  // Outputs
  assign prdata               = st_q.rdata;
  assign comparator_power_off = st_q.power_off;
  assign reference_select     = st_q.ref_sel;
  assign comparator_irq       = st_q.flag & st_q.irq_en & global_irq_enable;
  // Comparator replaces the capture pin, no other path
  assign capture_in           = st_q.capt ? sif.sync : capture_pin_in;
  assign pos_pin_buffer_off   = st_q.digital_input_disable[`ACMP_POS_OFF_BIT];
  assign neg_pin_buffer_off   = st_q.digital_input_disable[`ACMP_NEG_OFF_BIT];
  assign pos_pin_port_in      = st_q.pin_s[0] & ~st_q.digital_input_disable[0];
  assign neg_pin_port_in      = st_q.pin_s[1] & ~st_q.digital_input_disable[1];
  assign status_irq           = |(st_q.stat & st_q.sen);

  // =====================================================
  // Checks
  flag_set_a : assert property (@(posedge pclk) disable iff (!presetn)
    ev_hit |=> st_q.flag) else $error("event did not set flag");
  irq_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
    comparator_irq == (st_q.flag && st_q.irq_en && global_irq_enable))
    else $error("irq gating wrong");
  ack_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
    vector_ack && !ev_hit |=> !st_q.flag) else $error("ack did not clear");
  w1c_flag_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `ACMP_CTRL_OFFS && !pwdata[`ACMP_FLAG_BIT] && st_q.flag && !vector_ack
    |=> st_q.flag) else $error("zero write cleared flag");
  rsvd_mode_a : assert property (@(posedge pclk) disable iff (!presetn)
    st_q.mode == ACMP_MODE_RSVD |-> !ev_hit) else $error("reserved mode fired");
  rise_mode_a : assert property (@(posedge pclk) disable iff (!presetn)
    st_q.mode == ACMP_MODE_RISE && sif.fall |-> !ev_hit) else $error("fall in rise mode");
  capt_route_a : assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.capt |-> capture_in == capture_pin_in) else $error("capture route leak");
  pin_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    st_q.digital_input_disable[0] |-> !pos_pin_port_in) else $error("disabled pin reads one");
  digital_input_disable_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `ACMP_DIGITAL_INPUT_DISABLE_OFFS |=> pos_pin_buffer_off == $past(pwdata[0]))
    else $error("buffer off not written");
  cv_rise : cover property (@(posedge pclk) disable iff (!presetn) sif.rise ##1 st_q.flag);
  cv_irq : cover property (@(posedge pclk) disable iff (!presetn) comparator_irq ##1 vector_ack);
  cv_capt : cover property (@(posedge pclk) disable iff (!presetn) st_q.capt && sif.fall);
endmodule
`default_nettype wire

// file: sim/acmp_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Analog comparator core, levels in millivolts
module acmp_cmp_model #(
  parameter logic [11:0] BANDGAP_MV = 12'h4B0  // Plain default, not a trimmed value
) (
  input  wire logic [11:0] pos_mv,                // Positive pin level
  input  wire logic [11:0] neg_mv,                // Negative pin level
  input  wire logic        reference_select,      // Bandgap replaces positive pin
  input  wire logic        comparator_power_off,  // Core unpowered
  output logic             comparator_raw         // Asynchronous result
);
  logic [11:0] plus_mv;  // Level seen on the plus side
  // Reference mux ahead of the core
  assign plus_mv = reference_select ? BANDGAP_MV : pos_mv;
  // Unpowered core gives a steady low, never a stale value
  assign comparator_raw = !comparator_power_off && (plus_mv > neg_mv);
endmodule
`default_nettype wire

// file: sim/comparator_event_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acmp_cfg.svh"
// ==========================================
// Self-checking bench for the comparator block
module comparator_event_control_tb_top;
  import acmp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, raw, pwr_off, ref_sel;
  logic glb, vack, irq, cap_pin, cap_in, ppin, npin, pbo, nbo, ppi, npi, sirq;
  logic [11:0] paddr, pos_mv, neg_mv;
  logic [31:0] pwdata, prdata, r;
  int failures, n_compared;
  // One event case: mode, analog step, expected flag
  typedef struct {acmp_mode_t m; logic [11:0] a, b; logic f;} row_t;
  row_t rows [7] = '{'{ACMP_MODE_TOGGLE, 12'h100, 12'h300, 1'b1},
    '{ACMP_MODE_TOGGLE, 12'h300, 12'h100, 1'b1}, '{ACMP_MODE_RSVD, 12'h100, 12'h300, 1'b0},
    '{ACMP_MODE_FALL, 12'h300, 12'h100, 1'b1}, '{ACMP_MODE_FALL, 12'h100, 12'h300, 1'b0},
    '{ACMP_MODE_RISE, 12'h100, 12'h300, 1'b1}, '{ACMP_MODE_RISE, 12'h300, 12'h100, 1'b0}};
  // ==========================================
  // Design and far-side model
  acmp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .comparator_raw(raw), .comparator_power_off(pwr_off),
    .reference_select(ref_sel), .global_irq_enable(glb), .vector_ack(vack),
    .comparator_irq(irq), .capture_pin_in(cap_pin), .capture_in(cap_in),
    .positive_input_pin(ppin), .negative_input_pin(npin), .pos_pin_buffer_off(pbo),
    .neg_pin_buffer_off(nbo), .pos_pin_port_in(ppi), .neg_pin_port_in(npi),
    .status_irq(sirq));
  acmp_cmp_model i_cmp (.pos_mv(pos_mv), .neg_mv(neg_mv), .reference_select(ref_sel),
    .comparator_power_off(pwr_off), .comparator_raw(raw));
  // ==========================================
  // Clock, 25 ns period
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Verdict, the single place the run ends
  task automatic close_out();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog, far beyond the expected few hundred cycles
  initial
  begin
    #400000;
    failures++;
    close_out();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, glb, vack, cap_pin, ppin, npin} = '0;
    paddr = 12'h000; pwdata = 32'h0; pos_mv = 12'h100; neg_mv = 12'h200;
    failures = 0; n_compared = 0; presetn = 1'b0;
    wt(4);
    presetn <= 1'b1;
    // Reset values
    apb(0, `ACMP_CTRL_OFFS, 0); chk(r, 32'h0);
    apb(0, `ACMP_DIGITAL_INPUT_DISABLE_OFFS, 0); chk(r, 32'h0);
    apb(0, `ACMP_IRQ_EN_OFFS, 0); chk(r, 32'h0);
    apb(0, 12'h0FC, 0); chk(r, 32'h0);
    chk({pready, pslverr, irq, sirq}, 4'h8);
    $display("test reset done");
    // Event table: arm, clear flag, step, read back
    foreach (rows[i])
    begin
      @(posedge pclk) pos_mv <= rows[i].a;
      wt(6);
      apb(1, `ACMP_CTRL_OFFS, {27'h0, 3'h4, rows[i].m});
      @(posedge pclk) pos_mv <= rows[i].b;
      wt(6);
      apb(0, `ACMP_CTRL_OFFS, 0);
      chk(r[4], rows[i].f);
      chk(r[5], rows[i].b > neg_mv);
    end
    $display("test event table done");
    // Request gating, zero write, vector clear
    apb(1, `ACMP_CTRL_OFFS, 32'h13);
    @(posedge pclk) pos_mv <= 12'h300;
    wt(6);
    apb(1, `ACMP_CTRL_OFFS, 32'h0B);
    @(posedge pclk) glb <= 1'b1;
    wt(2); chk(irq, 1'b1);
    @(posedge pclk) glb <= 1'b0;
    wt(2); chk(irq, 1'b0);
    @(posedge pclk) glb <= 1'b1;
    apb(1, `ACMP_CTRL_OFFS, 32'h03);
    wt(2); chk(irq, 1'b0);
    apb(1, `ACMP_CTRL_OFFS, 32'h0B);
    @(posedge pclk) vack <= 1'b1;
    @(posedge pclk) vack <= 1'b0;
    wt(2); chk(irq, 1'b0);
    apb(0, `ACMP_CTRL_OFFS, 0); chk(r[4], 1'b0);
    $display("test request done");
    // Sticky status: raise, clear, mask
    apb(1, `ACMP_CTRL_OFFS, 32'h03);
    @(posedge pclk) pos_mv <= 12'h100;
    wt(6);
    apb(1, `ACMP_IRQ_EN_OFFS, 32'h2);
    apb(1, `ACMP_IRQ_CLR_OFFS, 32'h7);
    wt(2); chk(sirq, 1'b0);
    @(posedge pclk) pos_mv <= 12'h300;
    wt(6); chk(sirq, 1'b1);
    apb(0, `ACMP_IRQ_STAT_OFFS, 0); chk(r[2:1], 2'h1);
    apb(1, `ACMP_IRQ_CLR_OFFS, 32'h2);
    wt(2); chk(sirq, 1'b0);
    @(posedge pclk) pos_mv <= 12'h100;
    wt(6); chk(sirq, 1'b0);
    apb(0, `ACMP_IRQ_STAT_OFFS, 0); chk(r[2:1], 2'h2);
    $display("test status done");
    // Bandgap select, then power off
    apb(1, `ACMP_CTRL_OFFS, 32'h40);
    wt(6); chk(ref_sel, 1'b1);
    apb(0, `ACMP_CTRL_OFFS, 0); chk(r[5], 1'b1);
    apb(1, `ACMP_CTRL_OFFS, 32'hC0);
    wt(6); chk(pwr_off, 1'b1);
    apb(0, `ACMP_CTRL_OFFS, 0); chk(r[7:5], 3'h6);
    $display("test reference done");
    // Capture routing: pin when off, comparator when on
    @(posedge pclk) cap_pin <= 1'b1;
    apb(1, `ACMP_CTRL_OFFS, 32'h00);
    wt(2); chk(cap_in, 1'b1);
    apb(1, `ACMP_CTRL_OFFS, 32'h04);
    wt(2); chk(cap_in, 1'b0);
    @(posedge pclk) pos_mv <= 12'h300;
    // Timer's own capture interrupt enable lives outside this block
    wt(6); chk(cap_in, 1'b1);
    $display("test capture done");
    // Input buffer disables and forced-low port view
    @(posedge pclk) {ppin, npin} <= 2'b11;
    wt(4); chk({pbo, nbo, ppi, npi}, 4'h3);
    apb(1, `ACMP_DIGITAL_INPUT_DISABLE_OFFS, 32'h3);
    wt(4); chk({pbo, nbo, ppi, npi}, 4'hC);
    apb(0, `ACMP_DIGITAL_INPUT_DISABLE_OFFS, 0); chk(r, 32'h3);
    $display("test buffers done");
    close_out();
  end
endmodule
`default_nettype wire
